// ---- rtl/ips_pkg.sv ----
// Constants for the interrupt priority select block.
// Assumes an 8-bit special-function register space with page select.
package ips_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] IPS_PRIMARY_ADDR   = 8'hb8;
  localparam logic [7:0] IPS_EXTENDED_ADDR  = 8'hf7;
  localparam logic [7:0] IPS_EXT_PAGE_A     = 8'h00;
  localparam logic [7:0] IPS_EXT_PAGE_B     = 8'h0f;
  localparam logic [7:0] IPS_PRIMARY_RESET  = 8'h80;
  localparam logic [7:0] IPS_EXTENDED_RESET = 8'h00;
  localparam logic [7:0] IPS_PRIMARY_WMASK  = 8'h7f;
  localparam logic [7:0] IPS_EXTENDED_WMASK = 8'h07;
  localparam logic [7:0] IPS_PRIMARY_RO1    = 8'h80;

  // ==========================================================================
  // Field positions, primary register
  localparam int IPS_SERIAL_PERIPHERAL_PRIO_BIT = 6;
  localparam int IPS_TIMER_TWO_PRIO_BIT         = 5;
  localparam int IPS_ASYNC_SERIAL_PRIO_BIT      = 4;
  localparam int IPS_TIMER_ONE_PRIO_BIT         = 3;
  localparam int IPS_EXT_INPUT_ONE_PRIO_BIT     = 2;
  localparam int IPS_TIMER_ZERO_PRIO_BIT        = 1;
  localparam int IPS_EXT_INPUT_ZERO_PRIO_BIT    = 0;

  // ==========================================================================
  // Field positions, extended register
  localparam int IPS_PORT_MATCH_PRIO_BIT        = 2;
  localparam int IPS_CAN_CONTROLLER_PRIO_BIT    = 1;
  localparam int IPS_REGULATOR_DROPOUT_PRIO_BIT = 0;

  // ==========================================================================
  // Sources: seven primary then three extended
  localparam int IPS_NUM_SOURCES = 10;

  typedef enum logic [1:0] {
    IPS_IDLE,
    IPS_LOW,
    IPS_HIGH,
    IPS_HIGH_OVER_LOW
  } ips_level_t;

endpackage

// ---- rtl/ips_reg8.sv ----
// One 8-bit register with masked write and constant read-only bits.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns
module ips_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hff,
  parameter logic [7:0] RO_ONES   = 8'h00
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Write port
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       bit_wr_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic       bit_val_i,
  // Stored value
  output logic      [7:0] q_o
);

  logic [7:0] val_q;
  logic [7:0] val_d;

  // A bit cannot be writable and pinned to one at the same time.
  if ((WMASK & RO_ONES) != 8'h00) begin : g_bad_mask
    $error("ips_reg8 writable and pinned bits overlap");
  end

  // ==========================================================================
  // Next value
  always_comb begin
    val_d = val_q;
    if (wr_i) begin
      val_d = (val_q & ~WMASK) | (wdata_i & WMASK);
    end else if (bit_wr_i && WMASK[bit_sel_i]) begin
      val_d[bit_sel_i] = bit_val_i;
    end
    val_d = (val_d & WMASK) | RO_ONES;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      val_q <= RESET_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign q_o = val_q;

endmodule

// ---- rtl/ips_top.sv ----
// Interrupt priority select: two priority registers and a preemption tracker.
// Assumes the core presents special-function accesses on clk_i, one per cycle,
// and reports vector entry and return-from-interrupt as single-cycle pulses.
//
// Contract
// - Primary register at address b8, bit writable, visible on every page.
// - Primary bits 6..0 pick low or high level for seven sources.
// - Extended register at f7 answers only on pages 00 and 0f.
// - Extended bits 7..3 read zero; writes to them do nothing.
// - Extended bit 2 sets port-match interrupt to high when one.
// - Extended bit 1 sets CAN controller interrupt to high when one.
// - Extended bit 0 sets regulator dropout interrupt to high when one.
`timescale 1ns/1ns
module ips_top
  import ips_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  // Special-function register access
  input  wire logic [7:0]                 sfr_addr_i,
  input  wire logic [7:0]                 sfr_page_i,
  input  wire logic                       sfr_wr_i,
  input  wire logic                       sfr_rd_i,
  input  wire logic [7:0]                 sfr_wdata_i,
  input  wire logic                       sfr_bit_wr_i,
  input  wire logic [2:0]                 sfr_bit_sel_i,
  input  wire logic                       sfr_bit_val_i,
  output logic      [7:0]                 sfr_rdata_o,
  output logic                            sfr_hit_o,
  // Interrupt sources and core service events
  input  wire logic [IPS_NUM_SOURCES-1:0] irq_pending_i,
  input  wire logic                       irq_enter_i,
  input  wire logic                       irq_enter_high_i,
  input  wire logic                       irq_return_i,
  // Priority view for arbitration
  output logic [IPS_NUM_SOURCES-1:0]      src_high_o,
  output logic                            take_high_o,
  output logic                            take_low_o,
  output logic [1:0]                      service_level_o
);

  // ==========================================================================
  // Elaboration checks
  // The level map below wires seven primary and three extended sources only.
  if (IPS_NUM_SOURCES != 10) begin : g_bad_source_count
    $error("ips_top serves exactly ten interrupt sources");
  end

  // ==========================================================================
  // Address decode
  function automatic logic ips_ext_sel(input logic [7:0] addr, input logic [7:0] page);
    ips_ext_sel = (addr == IPS_EXTENDED_ADDR) &&
                  ((page == IPS_EXT_PAGE_A) || (page == IPS_EXT_PAGE_B));
  endfunction

  logic       pri_sel;
  logic       ext_sel;
  logic [7:0] pri_q;
  logic [7:0] ext_q;

  assign pri_sel = (sfr_addr_i == IPS_PRIMARY_ADDR);
  assign ext_sel = ips_ext_sel(sfr_addr_i, sfr_page_i);

  // ==========================================================================
  // Registers
  // Only the primary register is bit addressable, so bit writes gate on it.
  ips_reg8 #(
    .RESET_VAL (IPS_PRIMARY_RESET),
    .WMASK     (IPS_PRIMARY_WMASK),
    .RO_ONES   (IPS_PRIMARY_RO1)
  ) u_primary (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_i      (sfr_wr_i && pri_sel),
    .wdata_i   (sfr_wdata_i),
    .bit_wr_i  (sfr_bit_wr_i && pri_sel),
    .bit_sel_i (sfr_bit_sel_i),
    .bit_val_i (sfr_bit_val_i),
    .q_o       (pri_q)
  );

  ips_reg8 #(
    .RESET_VAL (IPS_EXTENDED_RESET),
    .WMASK     (IPS_EXTENDED_WMASK),
    .RO_ONES   (8'h00)
  ) u_extended (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_i      (sfr_wr_i && ext_sel),
    .wdata_i   (sfr_wdata_i),
    .bit_wr_i  (1'b0),
    .bit_sel_i (3'h0),
    .bit_val_i (1'b0),
    .q_o       (ext_q)
  );

  // ==========================================================================
  // Read data, registered
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       hit_q;
  logic       hit_d;

  always_comb begin
    rdata_d = 8'h00;
    hit_d   = 1'b0;
    if (sfr_rd_i && pri_sel) begin
      rdata_d = pri_q;
      hit_d   = 1'b1;
    end else if (sfr_rd_i && ext_sel) begin
      rdata_d = ext_q & IPS_EXTENDED_WMASK;
      hit_d   = 1'b1;
    end
  end

  // Read data stands for one cycle only, so a stale value never looks like a hit.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  // ==========================================================================
  // Per-source level map
  logic [IPS_NUM_SOURCES-1:0] high_map;
  always_comb begin
    high_map = '0;
    high_map[0] = pri_q[IPS_EXT_INPUT_ZERO_PRIO_BIT];
    high_map[1] = pri_q[IPS_TIMER_ZERO_PRIO_BIT];
    high_map[2] = pri_q[IPS_EXT_INPUT_ONE_PRIO_BIT];
    high_map[3] = pri_q[IPS_TIMER_ONE_PRIO_BIT];
    high_map[4] = pri_q[IPS_ASYNC_SERIAL_PRIO_BIT];
    high_map[5] = pri_q[IPS_TIMER_TWO_PRIO_BIT];
    high_map[6] = pri_q[IPS_SERIAL_PERIPHERAL_PRIO_BIT];
    high_map[7] = ext_q[IPS_PORT_MATCH_PRIO_BIT];
    high_map[8] = ext_q[IPS_CAN_CONTROLLER_PRIO_BIT];
    high_map[9] = ext_q[IPS_REGULATOR_DROPOUT_PRIO_BIT];
  end

  logic [IPS_NUM_SOURCES-1:0] src_high_q;

  // The view lags a register write by one cycle, as every output leaves a flip-flop.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      src_high_q <= '0;
    end else begin
      src_high_q <= high_map;
    end
  end

  // ==========================================================================
  // Service level tracker
  // A high service nested over a low one returns to the low level, not idle.
  ips_level_t lvl_q;
  ips_level_t lvl_d;
  logic       any_high;
  logic       any_low;
  logic       take_high_d;
  logic       take_low_d;

  assign any_high = |(irq_pending_i & high_map);
  assign any_low  = |(irq_pending_i & ~high_map);

  always_comb begin
    lvl_d = lvl_q;
    case (lvl_q)
      IPS_IDLE: begin
        if (irq_enter_i) begin
          lvl_d = irq_enter_high_i ? IPS_HIGH : IPS_LOW;
        end
      end
      IPS_LOW: begin
        if (irq_enter_i && irq_enter_high_i) begin
          lvl_d = IPS_HIGH_OVER_LOW;
        end else if (irq_return_i) begin
          lvl_d = IPS_IDLE;
        end
      end
      IPS_HIGH: begin
        if (irq_return_i) begin
          lvl_d = IPS_IDLE;
        end
      end
      IPS_HIGH_OVER_LOW: begin
        if (irq_return_i) begin
          lvl_d = IPS_LOW;
        end
      end
      default: lvl_d = IPS_IDLE;
    endcase
    take_high_d = any_high && (lvl_d == IPS_IDLE || lvl_d == IPS_LOW);
    take_low_d  = any_low && !any_high && (lvl_d == IPS_IDLE);
  end

  logic take_high_q;
  logic take_low_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lvl_q       <= IPS_IDLE;
      take_high_q <= 1'b0;
      take_low_q  <= 1'b0;
    end else begin
      lvl_q       <= lvl_d;
      take_high_q <= take_high_d;
      take_low_q  <= take_low_d;
    end
  end

  assign sfr_rdata_o     = rdata_q;
  assign sfr_hit_o       = hit_q;
  assign src_high_o      = src_high_q;
  assign take_high_o     = take_high_q;
  assign take_low_o      = take_low_q;
  assign service_level_o = lvl_q;

endmodule

// ---- testbench/interrupt_priority_select_test.sv ----
// ==========================================================================
// Self-checking bench for the interrupt priority select block.
// Assumes ips_top and its checker are compiled before this file.
`timescale 1ns/1ns
module interrupt_priority_select_test;
  logic       clk_i, reset_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_hit_o;
  logic       irq_enter_i, irq_enter_high_i, irq_return_i, take_high_o, take_low_o;
  logic [7:0] sfr_addr_i, sfr_page_i, sfr_wdata_i, sfr_rdata_o;
  logic [2:0] sfr_bit_sel_i;
  logic [1:0] service_level_o;
  logic [9:0] irq_pending_i, src_high_o;
  int         n_mismatch, samples_checked;
  ips_top i_ips_top (
    .clk_i            (clk_i),
    .reset_i          (reset_i),
    .sfr_addr_i       (sfr_addr_i),
    .sfr_page_i       (sfr_page_i),
    .sfr_wr_i         (sfr_wr_i),
    .sfr_rd_i         (sfr_rd_i),
    .sfr_wdata_i      (sfr_wdata_i),
    .sfr_bit_wr_i     (sfr_bit_wr_i),
    .sfr_bit_sel_i    (sfr_bit_sel_i),
    .sfr_bit_val_i    (sfr_bit_val_i),
    .sfr_rdata_o      (sfr_rdata_o),
    .sfr_hit_o        (sfr_hit_o),
    .irq_pending_i    (irq_pending_i),
    .irq_enter_i      (irq_enter_i),
    .irq_enter_high_i (irq_enter_high_i),
    .irq_return_i     (irq_return_i),
    .src_high_o       (src_high_o),
    .take_high_o      (take_high_o),
    .take_low_o       (take_low_o),
    .service_level_o  (service_level_o)
  );
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Inputs move 1 ns after the edge so the design samples settled values.
  task automatic cyc();
    @(posedge clk_i);
    #1;
  endtask
  // Each access ends with one idle edge, so no strobe falls and rises in one step.
  task automatic wr(input logic [7:0] a, p, d);
    {sfr_addr_i, sfr_page_i, sfr_wdata_i, sfr_wr_i} = {a, p, d, 1'b1};
    cyc();
    sfr_wr_i = 1'b0;
    cyc();
  endtask
  task automatic bwr(input logic [2:0] s, input logic v);
    {sfr_addr_i, sfr_bit_sel_i, sfr_bit_val_i, sfr_bit_wr_i} = {8'hb8, s, v, 1'b1};
    cyc();
    sfr_bit_wr_i = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, p, d, input logic h);
    {sfr_addr_i, sfr_page_i, sfr_rd_i} = {a, p, 1'b1};
    cyc();
    sfr_rd_i = 1'b0;
    chk({2'h0, sfr_rdata_o}, {2'h0, d});
    chk({9'h000, sfr_hit_o}, {9'h000, h});
    cyc();
  endtask
  // Event bits are enter, enter-high, return; take is {high, low}.
  task automatic ev(input logic [2:0] e, input logic [1:0] lvl, tk);
    {irq_enter_i, irq_enter_high_i, irq_return_i} = e;
    cyc();
    {irq_enter_i, irq_return_i} = 2'h0;
    chk({8'h00, service_level_o}, {8'h00, lvl});
    chk({8'h00, take_high_o, take_low_o}, {8'h00, tk});
    cyc();
  endtask
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_bit_sel_i} = 7'h00;
    {irq_enter_i, irq_enter_high_i, irq_return_i, irq_pending_i} = 13'h0000;
    {sfr_addr_i, sfr_page_i, sfr_wdata_i} = 24'h000000;
    {n_mismatch, samples_checked} = 0;
    reset_i = 1'b1;
    repeat (3) cyc();
    reset_i = 1'b0;
    rd(8'hb8, 8'h00, 8'h80, 1'b1);
    rd(8'hf7, 8'h0f, 8'h00, 1'b1);
    wr(8'hb8, 8'h05, 8'hff);
    rd(8'hb8, 8'h0a, 8'hff, 1'b1);
    chk(src_high_o, 10'h07f);
    wr(8'hb8, 8'h00, 8'h00);
    for (int i = 0; i < 7; i++) begin
      bwr(i[2:0], 1'b1);
      rd(8'hb8, 8'h33, 8'h80 | ((8'h02 << i) - 8'h01), 1'b1);
      chk(src_high_o, (10'h002 << i) - 10'h001);
    end
    bwr(3'h7, 1'b0);
    rd(8'hb8, 8'h00, 8'hff, 1'b1);
    wr(8'hf7, 8'h00, 8'hff);
    rd(8'hf7, 8'h00, 8'h07, 1'b1);
    chk(src_high_o, 10'h3ff);
    for (int i = 0; i < 3; i++) begin
      wr(8'hf7, 8'h0f, 8'h01 << i);
      rd(8'hf7, 8'h0f, 8'h01 << i, 1'b1);
      chk({7'h00, src_high_o[7], src_high_o[8], src_high_o[9]}, 10'h001 << i);
    end
    // A write on a foreign page must leave the extended value untouched.
    wr(8'hf7, 8'h01, 8'h03);
    rd(8'hf7, 8'h01, 8'h00, 1'b0);
    rd(8'hf7, 8'h00, 8'h04, 1'b1);
    rd(8'hd1, 8'h00, 8'h00, 1'b0);
    wr(8'hb8, 8'h00, 8'h01);
    irq_pending_i = 10'h003;
    cyc();
    // A pending high source holds back the low one, so only high may be taken.
    ev(3'h0, 2'h0, 2'h2);
    ev(3'h4, 2'h1, 2'h2);
    ev(3'h6, 2'h3, 2'h0);
    ev(3'h1, 2'h1, 2'h2);
    ev(3'h1, 2'h0, 2'h2);
    ev(3'h6, 2'h2, 2'h0);
    ev(3'h1, 2'h0, 2'h2);
    // Only a low source pending: taken when idle, never over any service.
    irq_pending_i = 10'h002;
    ev(3'h0, 2'h0, 2'h1);
    ev(3'h4, 2'h1, 2'h0);
    ev(3'h1, 2'h0, 2'h1);
    ev(3'h6, 2'h2, 2'h0);
    ev(3'h4, 2'h2, 2'h0);
    ev(3'h1, 2'h0, 2'h1);
    reset_i = 1'b1;
    cyc();
    reset_i = 1'b0;
    rd(8'hb8, 8'h00, 8'h80, 1'b1);
    rd(8'hf7, 8'h00, 8'h00, 1'b1);
    chk(src_high_o, 10'h000);
    chk({8'h00, service_level_o}, 10'h000);
    end_sim();
  end
endmodule

// ---- testbench/ips_monitor.sv ----
// ==========================================================================
// Port checker for the interrupt priority select block.
// Assumes it is bound to ips_top and runs on its single clock.
`timescale 1ns/1ns
module ips_monitor
  import ips_pkg::*;
(
  // Clock, reset and register access
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_sel_i,
  input wire logic       sfr_bit_val_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_hit_o,
  // Service events and priority view
  input wire logic       irq_enter_i,
  input wire logic       irq_enter_high_i,
  input wire logic       irq_return_i,
  input wire logic [9:0] src_high_o,
  input wire logic       take_high_o,
  input wire logic       take_low_o,
  input wire logic [1:0] service_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire ext_ok = sfr_addr_i == 8'hf7 && (sfr_page_i == 8'h00 || sfr_page_i == 8'h0f);
  wire prim_wr = sfr_wr_i && sfr_addr_i == 8'hb8;
  property p_prd; sfr_rd_i && sfr_addr_i == 8'hb8 |=> sfr_hit_o && sfr_rdata_o[7]; endproperty
  a_prd: assert property (p_prd) else $error("primary read");
  property p_pwr;
    prim_wr |=> ##1 {1'b1, src_high_o[6:0]} == ($past(sfr_wdata_i, 2) | 8'h80);
  endproperty
  a_pwr: assert property (p_pwr) else $error("primary write");
  property p_bwr;
    sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == 8'hb8 && sfr_bit_sel_i != 3'h7
      |=> ##1 src_high_o[$past(sfr_bit_sel_i, 2)] == $past(sfr_bit_val_i, 2);
  endproperty
  a_bwr: assert property (p_bwr) else $error("bit write");
  property p_page; sfr_rd_i && sfr_addr_i == 8'hf7 && !ext_ok |=> !sfr_hit_o; endproperty
  a_page: assert property (p_page) else $error("page decode");
  property p_rsv; sfr_rd_i && ext_ok |=> sfr_hit_o && sfr_rdata_o[7:3] == 5'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  // Port match lands on source 7 and regulator dropout on source 9.
  property p_ewr;
    sfr_wr_i && ext_ok |=> ##1 {5'h00, src_high_o[7], src_high_o[8], src_high_o[9]}
      == ($past(sfr_wdata_i, 2) & 8'h07);
  endproperty
  a_ewr: assert property (p_ewr) else $error("extended write");
  property p_low; take_low_o |-> service_level_o == 2'h0; endproperty
  a_low: assert property (p_low) else $error("low over service");
  property p_pre; irq_enter_i && irq_enter_high_i && service_level_o == 2'h1
    |=> service_level_o == 2'h3; endproperty
  a_pre: assert property (p_pre) else $error("no preemption");
  c_ext: cover property (sfr_rd_i && ext_ok);
  c_bit: cover property (sfr_bit_wr_i);
  c_nest: cover property (service_level_o == 2'h3);
  c_low: cover property (take_low_o);
  property p_high;
    take_high_o |-> service_level_o == 2'h0 || service_level_o == 2'h1;
  endproperty
  a_high: assert property (p_high) else $error("high over high service");
  property p_hold;
    irq_enter_i && !irq_enter_high_i && !irq_return_i && service_level_o[1]
      |=> service_level_o == $past(service_level_o);
  endproperty
  a_hold: assert property (p_hold) else $error("low preempted high");
endmodule
bind ips_top ips_monitor i_ips_monitor (
  .clk_i            (clk_i),
  .reset_i          (reset_i),
  .sfr_addr_i       (sfr_addr_i),
  .sfr_page_i       (sfr_page_i),
  .sfr_wr_i         (sfr_wr_i),
  .sfr_rd_i         (sfr_rd_i),
  .sfr_wdata_i      (sfr_wdata_i),
  .sfr_bit_wr_i     (sfr_bit_wr_i),
  .sfr_bit_sel_i    (sfr_bit_sel_i),
  .sfr_bit_val_i    (sfr_bit_val_i),
  .sfr_rdata_o      (sfr_rdata_o),
  .sfr_hit_o        (sfr_hit_o),
  .irq_enter_i      (irq_enter_i),
  .irq_enter_high_i (irq_enter_high_i),
  .irq_return_i     (irq_return_i),
  .src_high_o       (src_high_o),
  .take_high_o      (take_high_o),
  .take_low_o       (take_low_o),
  .service_level_o  (service_level_o)
);
